// ==== src/tpc_defs.svh ====
// register offsets, reset values and field widths for the timer pair
// assumes a 32-bit word-aligned bus map decoded on haddr[7:0]
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH
`define TPC_OFF_CTRL 8'h00
`define TPC_OFF_T2CMP 8'h04
`define TPC_OFF_T2PRE 8'h08
`define TPC_OFF_T3CMP1 8'h0C
`define TPC_OFF_T3CMP2 8'h10
`define TPC_OFF_CAPT 8'h14
`define TPC_OFF_STAT 8'h18
`define TPC_OFF_SHIFT 8'h1C
`define TPC_CTRL_W 10
`define TPC_RST_CTRL 10'h000
`define TPC_RST_T2CMP 12'h000
`define TPC_RST_T2PRE 4'h0
`define TPC_RST_T3CMP 8'h00
`define TPC_RST_SHIFT 8'h00
`endif

// ==== src/tpc_pkg.sv ====
// types shared by the timer pair coupling logic
// assumes tpc_defs.svh is on the include path
package tpc_pkg;
   // third timer operating modes
   typedef enum logic [3:0] {
      TPC_T3_PLAIN = 4'h0,
      TPC_T3_GATED = 4'h3,
      TPC_T3_BURST_T2 = 4'h6,
      TPC_T3_BURST_SO = 4'h7,
      TPC_T3_FSK = 4'h8
   } tpc_t3_mode_t;

   // control word, bit 0 upward: mode, split, single1/2, ext, t2 src, run
   typedef struct packed {
      logic run;
      logic t2_from_t3;
      logic t3_ext;
      logic single2;
      logic single1;
      logic t2_split;
      tpc_t3_mode_t t3_mode;
   } tpc_ctrl_t;

   // coupling signals between the timers and the shift unit
   typedef struct packed {
      logic t2_match_toggle;
      logic t2_prescale_match;
      logic t2_output_flop;
      logic t3_match_toggle;
      logic t3_output_flop;
      logic shift_data_out;
   } tpc_link_t;
endpackage : tpc_pkg

// ==== src/tpc_shift.sv ====
// sync_shift_unit: 8-bit rotating shift register with serial data out
// assumes load and shift are single-cycle pulses on hclk
`timescale 1ns/1ps
`include "tpc_defs.svh"
module tpc_shift (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic load,
   input wire logic [7:0] load_data,
   input wire logic shift,
   output logic [7:0] data,
   output logic so
);
   // load wins over shift; msb first, rotated back in
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data <= `TPC_RST_SHIFT;
      end else if (load) begin
         data <= load_data;
      end else if (shift) begin
         data <= {data[6:0], data[7]};
      end
   end

   assign so = data[7];
endmodule : tpc_shift

// ==== src/tpc_top.sv ====
// timer pair coupling: second timer, third timer and shift unit glue
// assumes an ahb-lite master on hclk and an async t3_input_pin
// Behaviour
// - in gated mode the third counter counts edges of its input pin
// - in gated mode each second-timer toggle resets the third counter
// - before that reset the third count is copied to capture
// - the gate trigger re-arms any single-action compares
// - mode 3 is counting with built-in restart and capture
// - the second timer runs 12-bit or 8-bit plus 4-bit prescaler
// - mode 6 gates the carrier burst with the second output flop
// - in mode 6 the second output flop enables the output pin
// - the second timer clocks from third toggle or system clock
// - the carrier comes from the third compare and output flop
// - in mode 7 the shift data output gates the output pin
// - in mode 7 the shift unit clocks on the second timer toggle
// - in mode 8 data low picks compare 1, data high compare 2
// - in mode 8 the two compares give two output frequencies
// - in mode 8 the prescaler match clocks the shift unit
//
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "tpc_defs.svh"
module tpc_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic t3_input_pin,
   output logic t3_output_pin,
   output tpc_pkg::tpc_link_t link
);
   import tpc_pkg::*;

   tpc_ctrl_t ctrl;
   logic [11:0] t2_cmp;
   logic [3:0] t2_pre_cmp;
   logic [7:0] t3_cmp1;
   logic [7:0] t3_cmp2;
   logic [7:0] capture;
   logic [11:0] t2_cnt;
   logic [3:0] t2_pre;
   logic t2_match_toggle;
   logic t2_prescale_match;
   logic t2_output_flop;
   logic [7:0] t3_cnt;
   logic t3_match_toggle;
   logic t3_output_flop;
   logic armed1;
   logic armed2;
   logic pin_s1;
   logic pin_s2;
   logic pin_s3;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic [7:0] shift_data;
   logic so;
   logic shift_load;
   logic shift_pulse;
   logic addr_ok;
   logic gated;
   logic fsk;
   logic t2_tick;
   logic pre_hit;
   logic t2_step;
   logic t2_hit;
   logic ext_edge;
   logic t3_tick;
   logic gate_trig;
   logic m1;
   logic m2;
   logic t3_restart;
   logic burst_gate;

   // word offset match for read and write decode
   function automatic logic sel(input logic [7:0] a, input logic [7:0] off);
      sel = (a == off);
   endfunction : sel

   // bus slave: zero wait, always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addr_ok = hsel && htrans[1] && hready;

   // write address phase held for the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= addr_ok && hwrite;
         wr_addr <= haddr[7:0];
      end
   end

   // software registers written in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= tpc_ctrl_t'(`TPC_RST_CTRL);
         t2_cmp <= `TPC_RST_T2CMP;
         t2_pre_cmp <= `TPC_RST_T2PRE;
         t3_cmp1 <= `TPC_RST_T3CMP;
         t3_cmp2 <= `TPC_RST_T3CMP;
      end else if (wr_pend) begin
         if (sel(wr_addr, `TPC_OFF_CTRL)) begin
            ctrl <= tpc_ctrl_t'(hwdata[`TPC_CTRL_W-1:0]);
         end
         if (sel(wr_addr, `TPC_OFF_T2CMP)) begin
            t2_cmp <= hwdata[11:0];
         end
         if (sel(wr_addr, `TPC_OFF_T2PRE)) begin
            t2_pre_cmp <= hwdata[3:0];
         end
         if (sel(wr_addr, `TPC_OFF_T3CMP1)) begin
            t3_cmp1 <= hwdata[7:0];
         end
         if (sel(wr_addr, `TPC_OFF_T3CMP2)) begin
            t3_cmp2 <= hwdata[7:0];
         end
      end
   end

   assign shift_load = wr_pend && sel(wr_addr, `TPC_OFF_SHIFT);

   // read data registered in the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_ok && !hwrite) begin
         hrdata <= 32'h0000_0000;
         if (sel(haddr[7:0], `TPC_OFF_CTRL)) begin
            hrdata[`TPC_CTRL_W-1:0] <= ctrl;
         end
         if (sel(haddr[7:0], `TPC_OFF_T2CMP)) begin
            hrdata[11:0] <= t2_cmp;
         end
         if (sel(haddr[7:0], `TPC_OFF_T2PRE)) begin
            hrdata[3:0] <= t2_pre_cmp;
         end
         if (sel(haddr[7:0], `TPC_OFF_T3CMP1)) begin
            hrdata[7:0] <= t3_cmp1;
         end
         if (sel(haddr[7:0], `TPC_OFF_T3CMP2)) begin
            hrdata[7:0] <= t3_cmp2;
         end
         if (sel(haddr[7:0], `TPC_OFF_CAPT)) begin
            hrdata[7:0] <= capture;
         end
         if (sel(haddr[7:0], `TPC_OFF_STAT)) begin
            hrdata[24:0] <= {armed2, armed1, so, t3_output_flop,
                             t2_output_flop, t2_cnt, t3_cnt};
         end
         if (sel(haddr[7:0], `TPC_OFF_SHIFT)) begin
            hrdata[7:0] <= shift_data;
         end
      end
   end

   // input pin synchroniser and rising edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
         pin_s3 <= 1'b0;
      end else begin
         pin_s1 <= t3_input_pin;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   // mode decode and second timer tick source
   assign gated = (ctrl.t3_mode == TPC_T3_GATED);
   assign fsk = (ctrl.t3_mode == TPC_T3_FSK);
   assign t2_tick = ctrl.run && (ctrl.t2_from_t3 ? t3_match_toggle : 1'b1);
   assign pre_hit = t2_tick && (t2_pre == t2_pre_cmp);
   assign t2_step = ctrl.t2_split ? pre_hit : t2_tick;
   assign t2_hit = t2_step && (ctrl.t2_split ? (t2_cnt[7:0] == t2_cmp[7:0])
                                             : (t2_cnt == t2_cmp));

   // second timer prescaler and counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         t2_pre <= 4'h0;
         t2_cnt <= 12'h000;
      end else begin
         if (t2_tick) begin
            t2_pre <= pre_hit ? 4'h0 : t2_pre + 4'h1;
         end
         if (t2_hit) begin
            t2_cnt <= 12'h000;
         end else if (t2_step) begin
            t2_cnt <= ctrl.t2_split ? {4'h0, t2_cnt[7:0] + 8'h01} : t2_cnt + 12'h001;
         end
      end
   end

   // second timer toggle pulse, prescale pulse, output flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         t2_match_toggle <= 1'b0;
         t2_prescale_match <= 1'b0;
         t2_output_flop <= 1'b0;
      end else begin
         t2_match_toggle <= t2_hit;
         t2_prescale_match <= pre_hit && ctrl.t2_split;
         t2_output_flop <= t2_output_flop ^ t2_hit;
      end
   end

   // third timer tick: pin edges in gated mode or ext select
   assign ext_edge = pin_s2 && !pin_s3;
   assign t3_tick = ctrl.run && ((gated || ctrl.t3_ext) ? ext_edge : 1'b1);
   assign gate_trig = ctrl.run && gated && t2_match_toggle;

   // compare matches; fsk picks compare by serial data
   assign m1 = t3_tick && (ctrl.single1 ? armed1 : 1'b1)
               && (t3_cnt == ((fsk && so) ? t3_cmp2 : t3_cmp1));
   assign m2 = t3_tick && !fsk && (ctrl.single2 ? armed2 : 1'b1)
               && (t3_cnt == t3_cmp2);
   assign t3_restart = m2 || (fsk && m1);

   // third counter with trigger restart taking priority
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         t3_cnt <= 8'h00;
      end else if (gate_trig) begin
         t3_cnt <= 8'h00;
      end else if (t3_restart) begin
         t3_cnt <= 8'h00;
      end else if (t3_tick) begin
         t3_cnt <= t3_cnt + 8'h01;
      end
   end

   // capture of the count gathered over the gate
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         capture <= 8'h00;
      end else if (gate_trig) begin
         capture <= t3_cnt;
      end
   end

   // single-action arming; trigger or control write re-arms
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         armed1 <= 1'b1;
         armed2 <= 1'b1;
      end else if (gate_trig || (wr_pend && sel(wr_addr, `TPC_OFF_CTRL))) begin
         armed1 <= 1'b1;
         armed2 <= 1'b1;
      end else begin
         if (m1 && ctrl.single1) begin
            armed1 <= 1'b0;
         end
         if (m2 && ctrl.single2) begin
            armed2 <= 1'b0;
         end
      end
   end

   // third toggle pulse and carrier flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         t3_match_toggle <= 1'b0;
         t3_output_flop <= 1'b0;
      end else begin
         t3_match_toggle <= m1 || m2;
         t3_output_flop <= t3_output_flop ^ (m1 || m2);
      end
   end

   // burst gate selection
   always_comb begin
      unique case (ctrl.t3_mode)
         TPC_T3_BURST_T2: burst_gate = t2_output_flop;
         TPC_T3_BURST_SO: burst_gate = so;
         default: burst_gate = 1'b1;
      endcase
   end

   // output pin held low while the gate is off
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         t3_output_pin <= 1'b0;
      end else begin
         t3_output_pin <= t3_output_flop && burst_gate;
      end
   end

   // shift clock: second toggle in mode 7, prescale match in mode 8
   assign shift_pulse = (ctrl.t3_mode == TPC_T3_BURST_SO) ? t2_match_toggle
                      : (fsk ? t2_prescale_match : 1'b0);

   tpc_shift u_shift (
      .hclk(hclk),
      .hresetn(hresetn),
      .load(shift_load),
      .load_data(hwdata[7:0]),
      .shift(shift_pulse),
      .data(shift_data),
      .so(so)
   );

   assign link = '{t2_match_toggle: t2_match_toggle,
                   t2_prescale_match: t2_prescale_match,
                   t2_output_flop: t2_output_flop,
                   t3_match_toggle: t3_match_toggle,
                   t3_output_flop: t3_output_flop,
                   shift_data_out: so};

   // checks on the coupling behaviour
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   ext_count_a: assert property (
      (ctrl.run && gated && !ext_edge && !gate_trig) |=> $stable(t3_cnt))
      else $error("gated counter moved without a pin edge");
   gate_reset_a: assert property (
      gate_trig |=> (t3_cnt == 8'h00))
      else $error("gate trigger did not clear the counter");
   capture_copy_a: assert property (
      gate_trig |=> (capture == $past(t3_cnt)))
      else $error("capture missed the count before reset");
   single_rearm_a: assert property (
      gate_trig |=> (armed1 && armed2))
      else $error("gate trigger did not re-arm single actions");
   t2_toggle_a: assert property (
      t2_hit |=> (t2_match_toggle && (t2_output_flop != $past(t2_output_flop))))
      else $error("second timer match did not toggle");
   burst_off_a: assert property (
      (ctrl.t3_mode == TPC_T3_BURST_T2 && !t2_output_flop) |=> !t3_output_pin)
      else $error("output pin active with burst gate off");
   so_gate_a: assert property (
      (ctrl.t3_mode == TPC_T3_BURST_SO && !so) |=> !t3_output_pin)
      else $error("output pin active with shift data low");
   shift_clock_a: assert property (
      (ctrl.t3_mode == TPC_T3_BURST_SO && t2_match_toggle && !shift_load)
      |=> (shift_data == {$past(shift_data[6:0]), $past(shift_data[7])}))
      else $error("shift unit not clocked by second toggle");
   fsk_select_a: assert property (
      (fsk && t3_tick && so && !ctrl.single1 && !gate_trig && t3_cnt == t3_cmp2)
      |=> (t3_match_toggle && t3_cnt == 8'h00))
      else $error("fsk did not use compare 2 for data high");
   fsk_shift_a: assert property (
      (fsk && t2_prescale_match && !shift_load)
      |=> (shift_data == {$past(shift_data[6:0]), $past(shift_data[7])}))
      else $error("prescale match did not clock the shift unit");

   gate_cover_c: cover property (gate_trig ##1 (capture != 8'h00));
   burst_cover_c: cover property (
      ctrl.t3_mode == TPC_T3_BURST_T2 && t3_output_pin ##1 !t2_output_flop);
   fsk_cover_c: cover property (fsk && so && t3_match_toggle);
endmodule : tpc_top

// ==== testbench/tpc_pin_model.sv ====
// pin model: external event source driving the third timer input pin
// assumes hclk is the system clock; the pin moves just after rising edges
`timescale 1ns/1ps
module tpc_pin_model (
   input wire logic hclk,
   input wire logic go,
   input wire logic [7:0] edges,
   output logic pin,
   output logic busy
);
   logic [7:0] left = 8'h00;
   logic [2:0] ph = 3'h0;
   initial begin
      pin = 1'b0;
      busy = 1'b0;
   end
   // each event is 4 cycles high then 4 low, slow enough for a synchroniser
   always @(posedge hclk) begin
      if (go && !busy) begin
         left <= edges;
         busy <= (edges != 8'h00);
         ph <= 3'h0;
      end else if (busy) begin
         ph <= ph + 3'h1;
         pin <= (ph < 3'h4);
         if (ph == 3'h7) begin
            left <= left - 8'h01;
            busy <= (left != 8'h01);
         end
      end
   end
endmodule : tpc_pin_model

// ==== testbench/tb_timer_pair_combination_modes.sv ====
// bench for the timer pair coupling: registers, gated count, burst and fsk
// assumes the pin model on t3_input_pin and one 50 MHz hclk
`timescale 1ns/1ps
`include "tpc_defs.svh"
module tb_timer_pair_combination_modes;
   import tpc_pkg::*;
   typedef struct packed {
      logic wr;
      logic [7:0] a;
      logic [31:0] wd;
      logic [31:0] exp;
   } tpc_row_t;
   logic hclk, hreadyout, hresp, t3_output_pin, busy, pin;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic go = 1'b0;
   logic [7:0] edges = 8'h00;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata, d;
   tpc_link_t link;
   int mismatches = 0;
   int check_count = 0;
   int c;
   // reset values, masks, a read-only and an unmapped place
   tpc_row_t rows [13] = '{
      '{1'b0, 8'h00, 32'h0000_0000, 32'h0000_0000},
      '{1'b0, 8'h04, 32'h0000_0000, 32'h0000_0000},
      '{1'b0, 8'h0C, 32'h0000_0000, 32'h0000_0000},
      '{1'b0, 8'h14, 32'h0000_0000, 32'h0000_0000},
      '{1'b0, 8'h18, 32'h0000_0000, 32'h0180_0000},
      '{1'b0, 8'h1C, 32'h0000_0000, 32'h0000_0000},
      '{1'b1, 8'h04, 32'hFFFF_FFFF, 32'h0000_0FFF},
      '{1'b1, 8'h08, 32'hFFFF_FFFF, 32'h0000_000F},
      '{1'b1, 8'h10, 32'hFFFF_FFFF, 32'h0000_00FF},
      '{1'b1, 8'h14, 32'hFFFF_FFFF, 32'h0000_0000},
      '{1'b1, 8'h1C, 32'h0000_00A5, 32'h0000_00A5},
      '{1'b1, 8'h20, 32'hFFFF_FFFF, 32'h0000_0000},
      '{1'b1, 8'h00, 32'hFFFF_FDF8, 32'h0000_01F8}
   };

   tpc_top tpc_top_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .t3_input_pin(pin),
      .t3_output_pin(t3_output_pin), .link(link)
   );
   tpc_pin_model tpc_pin_model_inst (
      .hclk(hclk), .go(go), .edges(edges), .pin(pin), .busy(busy)
   );

   // 50 MHz system clock
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // coupling signals sampled mid-cycle, away from the launching edge
   function automatic logic sig(input int k);
      case (k)
         0: return link.t2_match_toggle;
         1: return link.t3_match_toggle;
         2: return link.t2_prescale_match;
         default: return ~busy;
      endcase
   endfunction : sig

   task automatic wait_for(input int k, input int lim, output int n);
      for (n = 1; n <= lim; n++) begin
         @(negedge hclk);
         if (sig(k) === 1'b1) break;
      end
      if (n > lim) begin
         mismatches++;
         give_verdict();
      end
   endtask : wait_for

   task automatic period(input int k, input int exp, input string what);
      int n;
      wait_for(k, 2000, n);
      wait_for(k, 2000, n);
      check(what, n, exp);
   endtask : period

   task automatic ready_edge;
      int n;
      for (n = 0; n < 20; n++) begin
         @(posedge hclk);
         if (hreadyout === 1'b1) break;
      end
      if (n == 20) begin
         mismatches++;
         give_verdict();
      end
   endtask : ready_edge

   // one ahb-lite single transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      ready_edge();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      ready_edge();
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] junk;
      bus(1'b1, a, v, junk);
   endtask : wr

   task automatic do_reset;
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
   endtask : do_reset

   // fresh reset, then registers with control written last
   task automatic setup(input logic [31:0] t2, p, c1, c2, sh, ctl);
      do_reset();
      wr(`TPC_OFF_T2CMP, t2);
      wr(`TPC_OFF_T2PRE, p);
      wr(`TPC_OFF_T3CMP1, c1);
      wr(`TPC_OFF_T3CMP2, c2);
      wr(`TPC_OFF_SHIFT, sh);
      wr(`TPC_OFF_CTRL, ctl);
   endtask : setup

   // pin must follow carrier flop and gate one cycle late; shift data rotates
   task automatic watch(input int gm, input int cyc, input logic [7:0] sr);
      logic prev;
      logic gate;
      logic f2;
      logic f3;
      prev = 1'b0;
      f2 = 1'b0;
      f3 = 1'b0;
      for (int i = 0; i < cyc; i++) begin
         @(negedge hclk);
         if (i == 0) begin
            f2 = link.t2_output_flop;
            f3 = link.t3_output_flop;
         end else begin
            check("t3_output_pin", 32'(t3_output_pin), 32'(prev));
            f2 = f2 ^ (link.t2_match_toggle === 1'b1);
            f3 = f3 ^ (link.t3_match_toggle === 1'b1);
            check("t2_output_flop", 32'(link.t2_output_flop), 32'(f2));
            check("t3_output_flop", 32'(link.t3_output_flop), 32'(f3));
         end
         if (gm != 6) begin
            check("shift_data_out", 32'(link.shift_data_out), 32'(sr[7]));
            if ((gm == 7 ? link.t2_match_toggle : link.t2_prescale_match) === 1'b1) begin
               sr = {sr[6:0], sr[7]};
            end
         end
         gate = (gm == 6) ? link.t2_output_flop : (gm == 7) ? link.shift_data_out : 1'b1;
         prev = link.t3_output_flop & gate;
      end
   endtask : watch

   // main sequence
   initial begin
      do_reset();
      @(negedge hclk);
      check("link idle", 32'(link), 32'h0000_0000);
      check("hreadyout", 32'(hreadyout), 32'h0000_0001);
      check("hresp", 32'(hresp), 32'h0000_0000);
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            wr(rows[i].a, rows[i].wd);
         end
         bus(1'b0, rows[i].a, 32'h0000_0000, d);
         check($sformatf("reg %h", rows[i].a), d, rows[i].exp);
      end
      // gated event count with capture and single-action re-arm
      setup(32'h0000_00FF, 0, 32'h0000_0002, 32'h0000_00FF, 0, 32'h0000_02A3);
      edges <= 8'h05;
      go <= 1'b1;
      @(posedge hclk);
      go <= 1'b0;
      wait_for(3, 200, c);
      repeat (4) @(negedge hclk);
      bus(1'b0, `TPC_OFF_STAT, 32'h0000_0000, d);
      check("pin edge count", {24'h00_0000, d[7:0]}, 32'h0000_0005);
      check("single spent", 32'(d[23]), 32'h0000_0000);
      wait_for(0, 300, c);
      bus(1'b0, `TPC_OFF_CAPT, 32'h0000_0000, d);
      check("capture", d, 32'h0000_0005);
      bus(1'b0, `TPC_OFF_STAT, 32'h0000_0000, d);
      check("count restart", {24'h00_0000, d[7:0]}, 32'h0000_0000);
      check("single rearmed", 32'(d[23]), 32'h0000_0001);
      period(0, 256, "t2 period 12-bit");
      // burst gated by second timer flop, second timer clocked by carrier
      setup(1, 0, 32'h0000_0003, 32'h0000_0003, 0, 32'h0000_0306);
      period(1, 4, "carrier period");
      period(0, 8, "t2 from t3 period");
      watch(6, 100, 8'h00);
      // burst gated by shift data
      setup(5, 0, 32'h0000_0001, 32'h0000_0001, 32'h0000_00A5, 32'h0000_0207);
      watch(7, 80, 8'hA5);
      // fsk with the prescaler match as shift clock
      setup(4, 3, 32'h0000_0002, 32'h0000_0005, 32'h0000_003C, 32'h0000_0218);
      watch(8, 60, 8'h3C);
      period(2, 4, "prescale period");
      period(0, 20, "t2 period split");
      // fsk with shift data held low, then high
      for (int s = 0; s < 2; s++) begin
         setup(0, 0, 32'h0000_0002, 32'h0000_0005, (s == 1) ? 32'h80 : 32'h0, 32'h0000_0208);
         period(1, (s == 1) ? 6 : 3, "fsk interval");
      end
      give_verdict();
   end
endmodule : tb_timer_pair_combination_modes
